// ==== pmod_consts.svh ====
// Constants for the paged memory overlay decoder.
`ifndef PMOD_CONSTS_SVH
`define PMOD_CONSTS_SVH
`define PMOD_PWIN_BASE 16'h8000
`define PMOD_PWIN_LAST 16'hbfff
`define PMOD_UNPAGED_BASE 16'hc000
`define PMOD_DBG_ROM_BASE 16'hff20
`define PMOD_DBG_ROM_LAST 16'hffff
`define PMOD_DBG_REG_BASE 16'hff00
`define PMOD_DBG_REG_LAST 16'hff06
`define PMOD_REG_BASE_RST 16'h0000
`define PMOD_REG_SIZE 16'h0400
`define PMOD_VEC_BASE 16'hff80
`define PMOD_RAM_BASE_RST 16'h0800
`define PMOD_RAM_SIZE 16'h0400
`define PMOD_EE_BASE_RST 16'h1000
`define PMOD_EE_SIZE 16'h1000
`define PMOD_FL_BASE_RST 16'hc000
`define PMOD_FL_SIZE 16'h4000
`define PMOD_DWIN_BASE_RST 16'h7000
`define PMOD_DWIN_MASK_RST 16'hf000
`define PMOD_EWIN_BASE_RST 16'h0000
`define PMOD_EWIN_MASK_RST 16'hfc00
`define PMOD_PAGE_RST 8'h00
`define PMOD_CFG_PROGRAM_PAGE_SELECT 4'h0
`define PMOD_CFG_DATA_PAGE_SELECT 4'h1
`define PMOD_CFG_EXTRA_PAGE_SELECT 4'h2
`define PMOD_CFG_WIN_EN 4'h3
`define PMOD_CFG_REG_BASE 4'h4
`define PMOD_CFG_RAM_BASE 4'h5
`define PMOD_CFG_EE_BASE 4'h6
`define PMOD_CFG_FL_BASE 4'h7
`define PMOD_CFG_DWIN_BASE 4'h8
`define PMOD_CFG_DWIN_MASK 4'h9
`define PMOD_CFG_EWIN_BASE 4'ha
`define PMOD_CFG_EWIN_MASK 4'hb
`endif

// ==== pmod_pkg.sv ====
// Types for the paged memory overlay decoder.
package pmod_pkg;
  typedef enum logic [2:0] {
    pmod_sel_none,
    pmod_sel_regs,
    pmod_sel_vec_dbg,
    pmod_sel_ram,
    pmod_sel_eeprom,
    pmod_sel_flash,
    pmod_sel_window
  } pmod_sel_t;
endpackage

// ==== pmod_decoder.sv ====
// Paged memory overlay decoder: resource selects and expanded address.
// Function
// - One flat 64-Kbyte processor address space
// - Resources reset to default, software-relocatable bases
// - Full variant has program, data, extra windows
// - Program window fixed at 0x8000 to 0xBFFF
// - Data and extra windows configurable size, base
// - Page register picks one page per window
// - Reduced variant: program window, six-bit page
// - Data, extra pages written by ordinary accesses
// - Paged call and return write program page
// - Top block 0xC000 to 0xFFFF never paged
// - Fixed priority picks at most one resource
// - Debug ROM at 0xFF20 while debug active
// - Debug registers at 0xFF00 to 0xFF06 in debug
// - Debug resources absent during normal execution
// - Program window drives page on high lines
// - Outside enabled windows high lines driven one
// - Window enables reset cleared, gate translation
`timescale 1ns/100ps
`include "pmod_consts.svh"
module pmod_decoder #(
  parameter int FULL_VARIANT = 1,
  parameter int PAGE_W = 8,
  parameter int XADDR_W = 22
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_access,
  input wire logic cpu_write,
  input wire logic [15:0] cpu_wdata,
  input wire logic cfg_write,
  input wire logic [3:0] cfg_index,
  input wire logic [15:0] cfg_wdata,
  input wire logic call_page_write,
  input wire logic [7:0] call_page_value,
  input wire logic [15:0] data_page_select_reg_addr,
  input wire logic [15:0] extra_page_select_reg_addr,
  input wire logic background_debug_mode_enabled,
  input wire logic background_debug_mode_active,
  output pmod_pkg::pmod_sel_t resource_sel_q,
  output logic debug_reg_sel_q,
  output logic [XADDR_W-1:0] ext_addr_q,
  output logic [7:0] program_page_select_q,
  output logic [7:0] data_page_select_q,
  output logic [7:0] extra_page_select_q,
  output logic [2:0] window_enable_q
);
  localparam int PW = (FULL_VARIANT != 0) ? PAGE_W : 6;
  localparam logic [7:0] PMASK = 8'((1 << PW) - 1);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] program_page_select_d, data_page_select_d, extra_page_select_d;
  logic [2:0] wen_d;
  logic [15:0] reg_base_q, ram_base_q, ee_base_q, fl_base_q;
  logic [15:0] dwin_base_q, dwin_mask_q, ewin_base_q, ewin_mask_q;
  logic [15:0] reg_base_d, ram_base_d, ee_base_d, fl_base_d;
  logic [15:0] dwin_base_d, dwin_mask_d, ewin_base_d, ewin_mask_d;

  always_comb begin
    program_page_select_d = program_page_select_q;
    data_page_select_d = data_page_select_q;
    extra_page_select_d = extra_page_select_q;
    wen_d = window_enable_q;
    reg_base_d = reg_base_q;
    ram_base_d = ram_base_q;
    ee_base_d = ee_base_q;
    fl_base_d = fl_base_q;
    dwin_base_d = dwin_base_q;
    dwin_mask_d = dwin_mask_q;
    ewin_base_d = ewin_base_q;
    ewin_mask_d = ewin_mask_q;
    if (cfg_write) begin
      case (cfg_index)
        `PMOD_CFG_PROGRAM_PAGE_SELECT: program_page_select_d = cfg_wdata[7:0] & PMASK;
        `PMOD_CFG_DATA_PAGE_SELECT: data_page_select_d = cfg_wdata[7:0];
        `PMOD_CFG_EXTRA_PAGE_SELECT: extra_page_select_d = cfg_wdata[7:0];
        `PMOD_CFG_WIN_EN: wen_d = cfg_wdata[2:0];
        `PMOD_CFG_REG_BASE: reg_base_d = cfg_wdata;
        `PMOD_CFG_RAM_BASE: ram_base_d = cfg_wdata;
        `PMOD_CFG_EE_BASE: ee_base_d = cfg_wdata;
        `PMOD_CFG_FL_BASE: fl_base_d = cfg_wdata;
        `PMOD_CFG_DWIN_BASE: dwin_base_d = cfg_wdata;
        `PMOD_CFG_DWIN_MASK: dwin_mask_d = cfg_wdata;
        `PMOD_CFG_EWIN_BASE: ewin_base_d = cfg_wdata;
        `PMOD_CFG_EWIN_MASK: ewin_mask_d = cfg_wdata;
        default: ;
      endcase
    end
    // Ordinary writes page data and extra.
    if (cpu_access && cpu_write && FULL_VARIANT != 0) begin
      if (cpu_addr == data_page_select_reg_addr) data_page_select_d = cpu_wdata[7:0];
      if (cpu_addr == extra_page_select_reg_addr) extra_page_select_d = cpu_wdata[7:0];
    end
    // The call path wins over a same-cycle configuration write.
    // Paged call and return load page.
    if (call_page_write) program_page_select_d = call_page_value & PMASK;
    if (FULL_VARIANT == 0) begin
      data_page_select_d = `PMOD_PAGE_RST;
      extra_page_select_d = `PMOD_PAGE_RST;
      wen_d[2:1] = 2'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      program_page_select_q <= `PMOD_PAGE_RST;
      data_page_select_q <= `PMOD_PAGE_RST;
      extra_page_select_q <= `PMOD_PAGE_RST;
      window_enable_q <= 3'h0;
      reg_base_q <= `PMOD_REG_BASE_RST;
      ram_base_q <= `PMOD_RAM_BASE_RST;
      ee_base_q <= `PMOD_EE_BASE_RST;
      fl_base_q <= `PMOD_FL_BASE_RST;
      dwin_base_q <= `PMOD_DWIN_BASE_RST;
      dwin_mask_q <= `PMOD_DWIN_MASK_RST;
      ewin_base_q <= `PMOD_EWIN_BASE_RST;
      ewin_mask_q <= `PMOD_EWIN_MASK_RST;
    end else begin
      program_page_select_q <= program_page_select_d;
      data_page_select_q <= data_page_select_d;
      extra_page_select_q <= extra_page_select_d;
      window_enable_q <= wen_d;
      reg_base_q <= reg_base_d;
      ram_base_q <= ram_base_d;
      ee_base_q <= ee_base_d;
      fl_base_q <= fl_base_d;
      dwin_base_q <= dwin_base_d;
      dwin_mask_q <= dwin_mask_d;
      ewin_base_q <= ewin_base_d;
      ewin_mask_q <= ewin_mask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  pmod_pkg::pmod_sel_t sel_d;
  logic dbg_reg_d;
  logic [XADDR_W-1:0] xaddr_d;
  logic dbg_on, hit_p, hit_d, hit_e;
  logic [15:0] off_reg, off_ram, off_ee, off_fl;
  logic [4:0] dshift, eshift;

  always_comb begin
    // Offsets wrap within the 16-bit space.
    off_reg = cpu_addr - reg_base_q;
    off_ram = cpu_addr - ram_base_q;
    off_ee = cpu_addr - ee_base_q;
    off_fl = cpu_addr - fl_base_q;
    // Page sits above offset bits.
    // Wide windows leave fewer lines for the page, so high pages alias.
    dshift = 5'h00;
    eshift = 5'h00;
    for (int b = 0; b < 16; b++) begin
      dshift = dshift + 5'(!dwin_mask_q[b]);
      eshift = eshift + 5'(!ewin_mask_q[b]);
    end
    dbg_on = background_debug_mode_enabled && background_debug_mode_active;
    hit_p = window_enable_q[0] && cpu_addr >= `PMOD_PWIN_BASE && cpu_addr <= `PMOD_PWIN_LAST;
    hit_d = window_enable_q[1] && ((cpu_addr & dwin_mask_q) == (dwin_base_q & dwin_mask_q));
    hit_e = window_enable_q[2] && ((cpu_addr & ewin_mask_q) == (ewin_base_q & ewin_mask_q));
    if (cpu_addr >= `PMOD_UNPAGED_BASE) begin
      hit_d = 1'b0;
      hit_e = 1'b0;
    end
    dbg_reg_d = dbg_on && cpu_addr >= `PMOD_DBG_REG_BASE && cpu_addr <= `PMOD_DBG_REG_LAST;
    if (off_reg < `PMOD_REG_SIZE || dbg_reg_d)
      sel_d = pmod_pkg::pmod_sel_regs;
    else if ((dbg_on && cpu_addr >= `PMOD_DBG_ROM_BASE) || (!dbg_on && cpu_addr >= `PMOD_VEC_BASE))
      sel_d = pmod_pkg::pmod_sel_vec_dbg;
    else if (off_ram < `PMOD_RAM_SIZE)
      sel_d = pmod_pkg::pmod_sel_ram;
    else if (off_ee < `PMOD_EE_SIZE)
      sel_d = pmod_pkg::pmod_sel_eeprom;
    else if (off_fl < `PMOD_FL_SIZE)
      sel_d = pmod_pkg::pmod_sel_flash;
    else if (hit_p || hit_d || hit_e)
      sel_d = pmod_pkg::pmod_sel_window;
    else
      sel_d = pmod_pkg::pmod_sel_none;
    xaddr_d = {XADDR_W{1'b1}};
    xaddr_d[15:0] = cpu_addr;
    // Program page on lines above bit 13.
    if (hit_p)
      xaddr_d = XADDR_W'({program_page_select_q & PMASK, cpu_addr[13:0]});
    // One page of data or extra window.
    else if (hit_d)
      xaddr_d = XADDR_W'((24'(data_page_select_q) << dshift) | 24'(cpu_addr & ~dwin_mask_q));
    else if (hit_e)
      xaddr_d = XADDR_W'((24'(extra_page_select_q) << eshift) | 24'(cpu_addr & ~ewin_mask_q));
    // A cycle without an access selects nothing.
    if (!cpu_access) sel_d = pmod_pkg::pmod_sel_none;
  end

  ////////////////////////////////////////////////////////////////////////////

  // Decode registered once per access cycle.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      resource_sel_q <= pmod_pkg::pmod_sel_none;
      debug_reg_sel_q <= 1'b0;
      ext_addr_q <= {XADDR_W{1'b1}};
    end else begin
      resource_sel_q <= sel_d;
      debug_reg_sel_q <= dbg_reg_d && cpu_access;
      ext_addr_q <= xaddr_d;
    end
  end
endmodule

// ==== pmod_decoder_assertions.sv ====
// Assertions for the paged memory overlay decoder.
`timescale 1ns/100ps
module pmod_decoder_assertions (
  input wire logic ref_clk, reset_n, cpu_access, cpu_write, call_page_write,
  input wire logic background_debug_mode_enabled, background_debug_mode_active,
  input wire logic [15:0] cpu_addr, cpu_wdata, data_page_select_reg_addr,
  input wire logic [7:0] call_page_value, program_page_select_q, data_page_select_q,
  input wire pmod_pkg::pmod_sel_t resource_sel_q,
  input wire logic debug_reg_sel_q,
  input wire logic [21:0] ext_addr_q,
  input wire logic [2:0] window_enable_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire dbg = background_debug_mode_enabled && background_debug_mode_active;
  wire pwin = cpu_access && cpu_addr[15:14] == 2'b10;
  wire [13:0] offs = cpu_addr[13:0];
  wire [7:0] wlo = cpu_wdata[7:0];
  sequence s_pwin_hit;
    pwin && window_enable_q[0];
  endsequence
  sequence s_paged_out;
    resource_sel_q == pmod_pkg::pmod_sel_window;
  endsequence
  a_idle_sel_none: assert property (!cpu_access |=> resource_sel_q == pmod_pkg::pmod_sel_none)
    else $error("select without access");
  a_reset_state_clear: assert property (!$past(reset_n) |-> window_enable_q == 3'h0
    && program_page_select_q == 8'h00 && data_page_select_q == 8'h00) else $error("reset state");
  a_prog_page_out: assert property (s_pwin_hit |=> s_paged_out
    ##0 ext_addr_q == {$past(program_page_select_q), $past(offs)}) else $error("program window");
  a_window_off_ones: assert property (pwin && window_enable_q == 3'h0
    |=> ext_addr_q == {6'h3f, $past(cpu_addr)}) else $error("disabled window translated");
  a_top_never_paged: assert property (cpu_access && cpu_addr[15:14] == 2'b11
    |=> resource_sel_q != pmod_pkg::pmod_sel_window && ext_addr_q[21:16] == 6'h3f)
    else $error("top block paged");
  a_debug_reg_hit: assert property (cpu_access && dbg && cpu_addr inside {[16'hff00:16'hff06]}
    |=> debug_reg_sel_q) else $error("debug registers missed");
  a_debug_absent: assert property (!dbg |=> !debug_reg_sel_q) else $error("debug visible");
  a_debug_rom_hit: assert property (cpu_access && dbg && cpu_addr >= 16'hff20
    |=> resource_sel_q == pmod_pkg::pmod_sel_vec_dbg) else $error("debug rom missed");
  a_call_page_load: assert property (call_page_write
    |=> program_page_select_q == $past(call_page_value)) else $error("call page");
  a_data_page_load: assert property (cpu_access && cpu_write && cpu_addr == data_page_select_reg_addr
    |=> data_page_select_q == $past(wlo)) else $error("data page write");
endmodule
bind pmod_decoder pmod_decoder_assertions u_chk (.*);

// ==== pmod_cpu_model.sv ====
// Processor core model that issues addresses and paged calls.
`timescale 1ns/100ps
module pmod_cpu_model (
  input wire logic ref_clk,
  output logic [15:0] cpu_addr = 16'h0000,
  output logic cpu_access = 1'b0,
  output logic cpu_write = 1'b0,
  output logic [15:0] cpu_wdata = 16'h0000,
  output logic call_page_write = 1'b0,
  output logic [7:0] call_page_value = 8'h00
);
  task automatic drive(input logic [15:0] a, input logic acc, input logic w,
    input logic cw, input logic [15:0] d);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_access <= acc;
    cpu_write <= w;
    cpu_wdata <= acc ? d : ~d;
    call_page_write <= cw;
    call_page_value <= d[7:0];
  endtask
endmodule

// ==== pmod_decoder_test.sv ====
// Self-checking bench for the paged memory overlay decoder.
`timescale 1ns/100ps
module pmod_decoder_test;
  typedef struct packed {
    logic [15:0] a;
    logic d;
    pmod_pkg::pmod_sel_t s;
    logic [21:0] x;
  } pmod_row_t;
  logic ref_clk = 1'b0, reset_n = 1'b0, cfg_write = 1'b0;
  logic background_debug_mode_active = 1'b0;
  logic [3:0] cfg_index = 4'h0;
  logic [15:0] cfg_wdata = 16'h0000, cpu_addr, cpu_wdata;
  logic cpu_access, cpu_write, call_page_write, debug_reg_sel_q;
  logic [7:0] call_page_value, program_page_select_q, data_page_select_q, extra_page_select_q;
  logic [2:0] window_enable_q;
  logic [21:0] ext_addr_q;
  pmod_pkg::pmod_sel_t resource_sel_q;
  wire logic [15:0] data_page_select_reg_addr = 16'h0030;
  wire logic [15:0] extra_page_select_reg_addr = 16'h0031;
  logic background_debug_mode_enabled = 1'b1;
  int n_mismatch = 0, total_checks = 0;
  pmod_row_t rows [11];
  pmod_cpu_model cpu (.*);
  pmod_decoder dut (.*);
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [21:0] g, input logic [21:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cfg(input logic [3:0] i, input logic [15:0] v);
    @(posedge ref_clk);
    cfg_write <= 1'b1;
    cfg_index <= i;
    cfg_wdata <= v;
    @(posedge ref_clk);
    cfg_write <= 1'b0;
  endtask
  task automatic look(input logic [15:0] a, input logic w, input logic [15:0] d, input logic g);
    cpu.drive(a, 1'b1, w, 1'b0, d);
    background_debug_mode_active <= g;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  initial begin
    rows = '{'{16'h9000, 1'b0, pmod_pkg::pmod_sel_window, 22'h015000},
      '{16'hbfff, 1'b0, pmod_pkg::pmod_sel_window, 22'h017fff},
      '{16'hc100, 1'b0, pmod_pkg::pmod_sel_flash, 22'h3fc100},
      '{16'h0800, 1'b0, pmod_pkg::pmod_sel_ram, 22'h3f0800},
      '{16'h0100, 1'b0, pmod_pkg::pmod_sel_regs, 22'h3f0100},
      '{16'h1000, 1'b0, pmod_pkg::pmod_sel_eeprom, 22'h3f1000},
      '{16'h0400, 1'b0, pmod_pkg::pmod_sel_none, 22'h3f0400},
      '{16'hff90, 1'b0, pmod_pkg::pmod_sel_vec_dbg, 22'h3fff90},
      '{16'hff30, 1'b1, pmod_pkg::pmod_sel_vec_dbg, 22'h3fff30},
      '{16'hff30, 1'b0, pmod_pkg::pmod_sel_flash, 22'h3fff30},
      '{16'h7fff, 1'b0, pmod_pkg::pmod_sel_none, 22'h3f7fff}};
    @(posedge ref_clk);
    #1;
    chk({11'h0, window_enable_q, program_page_select_q}, 22'h0);
    chk(ext_addr_q, 22'h3fffff);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    look(16'h9000, 1'b0, 16'h0000, 1'b0);
    chk(ext_addr_q, 22'h3f9000);
    cfg(4'h0, 16'h0005);
    cfg(4'h3, 16'h0001);
    foreach (rows[i]) begin
      look(rows[i].a, 1'b0, 16'h0000, rows[i].d);
      chk({19'h0, resource_sel_q}, {19'h0, rows[i].s});
      chk(ext_addr_q, rows[i].x);
    end
    $display("map rows done");
    look(16'hff02, 1'b0, 16'h0000, 1'b1);
    chk({21'h0, debug_reg_sel_q}, 22'h1);
    look(16'hff02, 1'b0, 16'h0000, 1'b0);
    chk({21'h0, debug_reg_sel_q}, 22'h0);
    look(16'h0030, 1'b1, 16'h002a, 1'b0);
    chk({14'h0, data_page_select_q}, 22'h00002a);
    cpu.drive(16'h9000, 1'b0, 1'b0, 1'b1, 16'h007e);
    look(16'h9000, 1'b0, 16'h0000, 1'b0);
    chk(ext_addr_q, 22'h1f9000);
    cfg(4'h5, 16'h2000);
    look(16'h2000, 1'b0, 16'h0000, 1'b0);
    chk({19'h0, resource_sel_q}, {19'h0, pmod_pkg::pmod_sel_ram});
    $display("hand tests done");
    cfg(4'h3, 16'h0007);
    cfg(4'ha, 16'h6000);
    look(16'h0031, 1'b1, 16'h0011, 1'b0);
    chk({14'h0, extra_page_select_q}, 22'h000011);
    look(16'h7123, 1'b0, 16'h0000, 1'b0);
    chk({19'h0, resource_sel_q}, {19'h0, pmod_pkg::pmod_sel_window});
    chk(ext_addr_q, 22'h02a123);
    look(16'h6204, 1'b0, 16'h0000, 1'b0);
    chk(ext_addr_q, 22'h004604);
    @(posedge ref_clk);
    background_debug_mode_enabled <= 1'b0;
    look(16'hff30, 1'b0, 16'h0000, 1'b1);
    chk({19'h0, resource_sel_q}, {19'h0, pmod_pkg::pmod_sel_flash});
    $display("window tests done");
    final_report();
  end
endmodule
